// ==== design/rtc_defs.vh ====
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH
// ------------------------------------------------------------
// register map, 5-bit address, 8-bit data
// ------------------------------------------------------------
`define RTC_A_SEC     5'h00
`define RTC_A_MIN     5'h01
`define RTC_A_HOUR    5'h02
`define RTC_A_DATE    5'h03
`define RTC_A_MON     5'h04
`define RTC_A_YEAR    5'h05
`define RTC_A_DOW     5'h06
`define RTC_A_CTRL    5'h07
`define RTC_A_FSEL    5'h08
`define RTC_A_ALSEC   5'h09
`define RTC_A_ALMIN   5'h0A
`define RTC_A_ALHOUR  5'h0B
`define RTC_A_ALDOW   5'h0C
`define RTC_A_ALDATE  5'h0D
`define RTC_A_ALMON   5'h0E
`define RTC_A_STAT    5'h0F
`define RTC_A_ICLR    5'h10
`define RTC_A_IEN     5'h11
`define RTC_A_USR0    5'h12
`define RTC_A_USR1    5'h13
// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define RTC_CTRL_PINFREQ 0
`define RTC_CTRL_PULSE   1
`define RTC_ST_ALARM     0
`define RTC_ST_EVENT     1
`define RTC_AL_EN        7
`define RTC_DIV          32768
`define RTC_I2C_ADDR     7'h6F
`endif

// ==== design/rtc_i2c_slave.v ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.vh"
module rtc_i2c_slave #(
    parameter [6:0] DEV_ADDR = `RTC_I2C_ADDR
) (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       sclIn,
    input  wire       sdaIn,
    output reg        sdaOe,
    output reg  [4:0] regAddr,
    output reg  [7:0] regWdata,
    output reg        regWr,
    output reg        regRd,
    input  wire [7:0] regRdata
);
    localparam [3:0] S_IDLE = 4'h0, S_ADDR = 4'h1, S_ACKA = 4'h2, S_PTR = 4'h3,
                     S_ACKP = 4'h4, S_WDAT = 4'h5, S_ACKW = 4'h6, S_RDAT = 4'h7,
                     S_ACKR = 4'h8;
    // ------------------------------------------------------------
    // pin synchronisers, third stage only for edge detection
    // ------------------------------------------------------------
    reg [2:0] sclSh_q;
    reg [2:0] sdaSh_q;
    reg [3:0] st_q;
    reg [2:0] bitCnt_q;
    reg [7:0] rxb_q;
    reg [7:0] txb_q;
    reg       byteDone_q;
    reg       rw_q;
    reg       nack_q;
    reg       rdPend_q;
    wire sclRise = sclSh_q[1] & ~sclSh_q[2];
    wire sclFall = ~sclSh_q[1] & sclSh_q[2];
    wire startC  = sclSh_q[1] & sclSh_q[2] & sdaSh_q[2] & ~sdaSh_q[1];
    wire stopC   = sclSh_q[1] & sclSh_q[2] & ~sdaSh_q[2] & sdaSh_q[1];
    wire rxSt    = (st_q == S_ADDR) | (st_q == S_PTR) | (st_q == S_WDAT);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclSh_q <= 3'h7;
            sdaSh_q <= 3'h7;
        end else begin
            sclSh_q <= {sclSh_q[1:0], sclIn};
            sdaSh_q <= {sdaSh_q[1:0], sdaIn};
        end
    end
    // ------------------------------------------------------------
    // byte engine; sda changes only after scl falls
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= S_IDLE; bitCnt_q <= 3'h0; rxb_q <= 8'h00; txb_q <= 8'h00;
            byteDone_q <= 1'b0; rw_q <= 1'b0; nack_q <= 1'b0; rdPend_q <= 1'b0;
            sdaOe <= 1'b0; regAddr <= 5'h00; regWdata <= 8'h00;
            regWr <= 1'b0; regRd <= 1'b0;
        end else begin
            regWr    <= 1'b0;
            regRd    <= 1'b0;
            rdPend_q <= regRd;
            if (rdPend_q)
                txb_q <= regRdata;
            if (startC) begin
                st_q <= S_ADDR; bitCnt_q <= 3'h0; byteDone_q <= 1'b0; sdaOe <= 1'b0;
            end else if (stopC) begin
                st_q <= S_IDLE; sdaOe <= 1'b0;
            end else if (sclRise) begin
                if (rxSt | (st_q == S_RDAT)) begin
                    rxb_q    <= {rxb_q[6:0], sdaSh_q[1]};
                    bitCnt_q <= bitCnt_q + 3'h1;
                    if (bitCnt_q == 3'h7)
                        byteDone_q <= 1'b1;
                end
                if (st_q == S_ACKR)
                    nack_q <= sdaSh_q[1];
            end else if (sclFall) begin
                if (byteDone_q) begin
                    byteDone_q <= 1'b0;
                    case (st_q)
                        S_ADDR: begin
                            if (rxb_q[7:1] == DEV_ADDR) begin
                                sdaOe <= 1'b1; rw_q <= rxb_q[0]; st_q <= S_ACKA;
                                regRd <= rxb_q[0];
                            end else begin
                                st_q <= S_IDLE;
                            end
                        end
                        S_PTR: begin
                            sdaOe <= 1'b1; regAddr <= rxb_q[4:0]; st_q <= S_ACKP;
                        end
                        S_WDAT: begin
                            sdaOe <= 1'b1; regWdata <= rxb_q; regWr <= 1'b1; st_q <= S_ACKW;
                        end
                        S_RDAT: begin
                            sdaOe <= 1'b0; st_q <= S_ACKR;
                            regAddr <= regAddr + 5'h01; regRd <= 1'b1;
                        end
                        default: st_q <= S_IDLE;
                    endcase
                end else begin
                    case (st_q)
                        S_ACKA: begin
                            st_q <= rw_q ? S_RDAT : S_PTR;
                            sdaOe <= rw_q & ~txb_q[7];
                        end
                        S_ACKP: begin
                            sdaOe <= 1'b0; st_q <= S_WDAT;
                        end
                        S_ACKW: begin
                            sdaOe <= 1'b0; st_q <= S_WDAT; regAddr <= regAddr + 5'h01;
                        end
                        S_ACKR: begin
                            st_q  <= nack_q ? S_IDLE : S_RDAT;
                            sdaOe <= ~nack_q & ~txb_q[7];
                        end
                        S_RDAT: begin
                            txb_q <= {txb_q[6:0], 1'b0};
                            sdaOe <= ~txb_q[6];
                        end
                        default: sdaOe <= 1'b0;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/rtc_cal_evt.v ====
// What this block does
// - separate time and calendar counters, carry-chained
// - automatic leap years, correct through 2099
// - time base counts 32.768 kHz reference edges
// - event seen while event input is high
// - event detect pin pulled low, open drain
// - shared pin: interrupt or frequency, per config
// - fifteen selectable output frequencies
// - alarm matches any enabled field combination
// - alarm single-event hold, or repeated pulses on the shared pin only
// - two bytes of host read-write user storage
// - serial data driven open drain only
// - serial link works up to 400 kHz
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.vh"
module rtc_cal_evt #(
    parameter        DIV = `RTC_DIV,
    parameter        PW  = 15
) (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire [4:0] regAddr,
    input  wire [7:0] regWdata,
    input  wire       regWr,
    input  wire       regRd,
    output reg  [7:0] regRdata,
    input  wire       oscIn,
    output reg        oscOut,
    input  wire       eventInput,
    output reg        eventDetectOut,
    output reg        eventDetectOe,
    input  wire       sclIn,
    input  wire       sdaIn,
    output reg        sdaOut,
    output wire       sdaOe,
    output reg        irqOrFreqOut,
    output reg        irqOrFreqOe,
    output reg        intr
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [2:0]    oscSh_q;
    reg [1:0]    evSh_q;
    reg [PW-1:0] presc_q;
    reg          secTick_q;
    reg          tickDone_q;
    reg [5:0]    sec_q;
    reg [5:0]    min_q;
    reg [4:0]    hour_q;
    reg [4:0]    date_q;
    reg [3:0]    mon_q;
    reg [6:0]    year_q;
    reg [2:0]    dow_q;
    reg [7:0]    ctrl_q;
    reg [3:0]    fsel_q;
    reg [7:0]    al_q [0:5];
    reg [1:0]    stat_q;
    reg [1:0]    ien_q;
    reg [7:0]    usr_q [0:1];
    reg [1:0]    stat_d;
    wire [4:0]   i2cAddr;
    wire [7:0]   i2cWdata;
    wire         i2cWr;
    wire         i2cRd;
    reg  [7:0]   i2cRdata_q;
    integer      k;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // 2000 is a leap year, so year mod 4 suffices through 2099
    function [4:0] monthDays;
        input [3:0] m;
        input [6:0] y;
        begin
            case (m)
                4'h2:    monthDays = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
                4'h4, 4'h6, 4'h9, 4'hB: monthDays = 5'h1E;
                default: monthDays = 5'h1F;
            endcase
        end
    endfunction

    function [7:0] readReg;
        input [4:0] a;
        begin
            case (a)
                `RTC_A_SEC:    readReg = {2'h0, sec_q};
                `RTC_A_MIN:    readReg = {2'h0, min_q};
                `RTC_A_HOUR:   readReg = {3'h0, hour_q};
                `RTC_A_DATE:   readReg = {3'h0, date_q};
                `RTC_A_MON:    readReg = {4'h0, mon_q};
                `RTC_A_YEAR:   readReg = {1'b0, year_q};
                `RTC_A_DOW:    readReg = {5'h00, dow_q};
                `RTC_A_CTRL:   readReg = ctrl_q;
                `RTC_A_FSEL:   readReg = {4'h0, fsel_q};
                `RTC_A_ALSEC:  readReg = al_q[0];
                `RTC_A_ALMIN:  readReg = al_q[1];
                `RTC_A_ALHOUR: readReg = al_q[2];
                `RTC_A_ALDOW:  readReg = al_q[3];
                `RTC_A_ALDATE: readReg = al_q[4];
                `RTC_A_ALMON:  readReg = al_q[5];
                `RTC_A_STAT:   readReg = {6'h00, stat_q};
                `RTC_A_IEN:    readReg = {6'h00, ien_q};
                `RTC_A_USR0:   readReg = usr_q[0];
                `RTC_A_USR1:   readReg = usr_q[1];
                default:       readReg = 8'h00;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // serial port; the host owns scl, we only pull sda low
    // ------------------------------------------------------------
    // scl only sampled
    // 200 MHz oversampling covers 400 kHz
    rtc_i2c_slave u_i2c (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .sclIn    (sclIn),
        .sdaIn    (sdaIn),
        .sdaOe    (sdaOe),
        .regAddr  (i2cAddr),
        .regWdata (i2cWdata),
        .regWr    (i2cWr),
        .regRd    (i2cRd),
        .regRdata (i2cRdata_q)
    );

    // plain port wins a same-cycle write clash; the serial write is dropped
    wire       wEn = regWr | i2cWr;
    wire [4:0] wA  = regWr ? regAddr : i2cAddr;
    wire [7:0] wD  = regWr ? regWdata : i2cWdata;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regRdata   <= 8'h00;
            i2cRdata_q <= 8'h00;
            sdaOut     <= 1'b0;
        end else begin
            regRdata   <= regRd ? readReg(regAddr) : 8'h00;
            i2cRdata_q <= i2cRd ? readReg(i2cAddr) : i2cRdata_q;
            sdaOut     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // reference sampling and prescaler
    // ------------------------------------------------------------
    wire oscRise = oscSh_q[1] & ~oscSh_q[2];

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            oscSh_q   <= 3'h0;
            presc_q   <= {PW{1'b0}};
            secTick_q <= 1'b0;
            oscOut    <= 1'b1;
        end else begin
            oscSh_q   <= {oscSh_q[1:0], oscIn};
            oscOut    <= ~oscSh_q[1];
            secTick_q <= 1'b0;
            if (oscRise) begin
                if (presc_q == DIV[PW-1:0] - {{(PW-1){1'b0}}, 1'b1}) begin
                    presc_q   <= {PW{1'b0}};
                    secTick_q <= 1'b1;
                end else begin
                    presc_q <= presc_q + {{(PW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // time and calendar counters; a write beats the tick
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sec_q <= 6'h00; min_q <= 6'h00; hour_q <= 5'h00; date_q <= 5'h01;
            mon_q <= 4'h1;  year_q <= 7'h00; dow_q <= 3'h0; tickDone_q <= 1'b0;
        end else begin
            tickDone_q <= secTick_q;
            if (secTick_q) begin
                sec_q <= (sec_q == 6'h3B) ? 6'h00 : sec_q + 6'h01;
                if (sec_q == 6'h3B) begin
                    min_q <= (min_q == 6'h3B) ? 6'h00 : min_q + 6'h01;
                    if (min_q == 6'h3B) begin
                        hour_q <= (hour_q == 5'h17) ? 5'h00 : hour_q + 5'h01;
                        if (hour_q == 5'h17) begin
                            dow_q <= (dow_q == 3'h6) ? 3'h0 : dow_q + 3'h1;
                            if (date_q >= monthDays(mon_q, year_q)) begin
                                date_q <= 5'h01;
                                mon_q  <= (mon_q == 4'hC) ? 4'h1 : mon_q + 4'h1;
                                if (mon_q == 4'hC)
                                    year_q <= (year_q == 7'h63) ? 7'h00 : year_q + 7'h01;
                            end else begin
                                date_q <= date_q + 5'h01;
                            end
                        end
                    end
                end
            end
            if (wEn) begin
                case (wA)
                    `RTC_A_SEC:  sec_q  <= wD[5:0];
                    `RTC_A_MIN:  min_q  <= wD[5:0];
                    `RTC_A_HOUR: hour_q <= wD[4:0];
                    `RTC_A_DATE: date_q <= wD[4:0];
                    `RTC_A_MON:  mon_q  <= wD[3:0];
                    `RTC_A_YEAR: year_q <= wD[6:0];
                    `RTC_A_DOW:  dow_q  <= wD[2:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // configuration, alarm and user storage
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= 8'h00;
            fsel_q <= 4'h0;
            ien_q  <= 2'h0;
            for (k = 0; k < 6; k = k + 1)
                al_q[k] <= 8'h00;
            usr_q[0] <= 8'h00;
            usr_q[1] <= 8'h00;
        end else if (wEn) begin
            case (wA)
                `RTC_A_CTRL:   ctrl_q   <= wD;
                `RTC_A_FSEL:   fsel_q   <= wD[3:0];
                `RTC_A_ALSEC:  al_q[0]  <= wD;
                `RTC_A_ALMIN:  al_q[1]  <= wD;
                `RTC_A_ALHOUR: al_q[2]  <= wD;
                `RTC_A_ALDOW:  al_q[3]  <= wD;
                `RTC_A_ALDATE: al_q[4]  <= wD;
                `RTC_A_ALMON:  al_q[5]  <= wD;
                `RTC_A_IEN:    ien_q    <= wD[1:0];
                `RTC_A_USR0:   usr_q[0] <= wD;
                `RTC_A_USR1:   usr_q[1] <= wD;
                default: ;
            endcase
        end
    end

    // each field is either disabled or equal; at least one enabled
    wire [5:0] alHit;
    assign alHit[0] = ~al_q[0][`RTC_AL_EN] | (al_q[0][5:0] == sec_q);
    assign alHit[1] = ~al_q[1][`RTC_AL_EN] | (al_q[1][5:0] == min_q);
    assign alHit[2] = ~al_q[2][`RTC_AL_EN] | (al_q[2][4:0] == hour_q);
    assign alHit[3] = ~al_q[3][`RTC_AL_EN] | (al_q[3][2:0] == dow_q);
    assign alHit[4] = ~al_q[4][`RTC_AL_EN] | (al_q[4][4:0] == date_q);
    assign alHit[5] = ~al_q[5][`RTC_AL_EN] | (al_q[5][3:0] == mon_q);
    wire alAny = al_q[0][`RTC_AL_EN] | al_q[1][`RTC_AL_EN] | al_q[2][`RTC_AL_EN] |
                 al_q[3][`RTC_AL_EN] | al_q[4][`RTC_AL_EN] | al_q[5][`RTC_AL_EN];
    wire alMatch = tickDone_q & alAny & (&alHit);

    // ------------------------------------------------------------
    // status, event and interrupt pin
    // ------------------------------------------------------------
    wire clrWr = wEn & (wA == `RTC_A_ICLR);

    always @* begin
        stat_d = stat_q;
        if (clrWr)
            stat_d = stat_q & ~wD[1:0];
        if (alMatch)
            stat_d[`RTC_ST_ALARM] = 1'b1;
        if (evSh_q[1])
            stat_d[`RTC_ST_EVENT] = 1'b1;
    end

    wire [3:0] fIdx    = fsel_q - 4'h2;
    // 1 = reference, 2..15 = prescaler taps
    wire       freqLvl = (fsel_q == 4'h1) ? oscSh_q[1] : presc_q[fIdx];
    // pulse mode: first eighth of every second
    wire       pulseOn = ~ctrl_q[`RTC_CTRL_PULSE] | (presc_q < DIV[PW+2:3]);
    wire       irqAct  = (stat_q[`RTC_ST_ALARM] & ien_q[`RTC_ST_ALARM] & pulseOn) |
                         (stat_q[`RTC_ST_EVENT] & ien_q[`RTC_ST_EVENT]);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            evSh_q         <= 2'h0;
            stat_q         <= 2'h0;
            eventDetectOut <= 1'b0;
            eventDetectOe  <= 1'b0;
            irqOrFreqOut   <= 1'b0;
            irqOrFreqOe    <= 1'b0;
            intr           <= 1'b0;
        end else begin
            evSh_q        <= {evSh_q[0], eventInput};
            stat_q        <= stat_d;
            // pull low while event flag set
            eventDetectOe <= stat_d[`RTC_ST_EVENT];
            intr          <= |(stat_d & ien_q);
            if (ctrl_q[`RTC_CTRL_PINFREQ])
                irqOrFreqOe <= (fsel_q != 4'h0) & ~freqLvl;
            else
                irqOrFreqOe <= irqAct;
        end
    end
endmodule
`default_nettype wire

// ==== tb/rtc_cal_evt_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.vh"
module rtc_chk (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdata,
    input wire logic       oscIn,
    input wire logic       oscOut,
    input wire logic       eventInput,
    input wire logic       eventDetectOut,
    input wire logic       eventDetectOe,
    input wire logic       sclIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       irqOrFreqOut
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_osc_inverts: assert property ($changed(oscIn) |-> ##[1:5] (oscOut != oscIn))
        else $error("amplifier output does not invert the reference");
    a_event_seen: assert property (eventInput [*3] |-> ##[1:5] eventDetectOe)
        else $error("event input high without detect");
    a_event_detect_out_pull: assert property (eventDetectOut == 1'b0)
        else $error("event detect pin driven high");
    a_event_detect_out_hold: assert property (eventDetectOe && !(regWr && regAddr == `RTC_A_ICLR) |=> eventDetectOe)
        else $error("event detect dropped without a clear");
    a_event_detect_out_clear: assert property (!eventInput [*4] ##0 (regWr && regAddr == `RTC_A_ICLR && regWdata[1])
        |-> ##[1:3] !eventDetectOe)
        else $error("event clear ignored while input low");
    a_sda_still: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data line moved while serial clock high");
    a_sda_drive: assert property (sdaOut == 1'b0)
        else $error("data line driven high");
    a_pin_pull: assert property (irqOrFreqOut == 1'b0)
        else $error("shared pin driven high");
    a_usr_store: assert property ((regWr && (regAddr == `RTC_A_USR0 || regAddr == `RTC_A_USR1)) ##1
        (regRd && regAddr == $past(regAddr)) |=> regRdata == $past(regWdata, 2))
        else $error("user byte read back wrong");
    a_read_idle: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data outside its cycle");
endmodule
`default_nettype wire

// ==== tb/rtc_i2c_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_host (
    output logic      sclLine,
    output logic      sdaLow,
    input  wire logic sdaLine
);
    int halfNs = 1250;
    initial begin
        sclLine = 1'b1;
        sdaLow  = 1'b0;
    end
    task automatic start();
        sdaLow = 1'b0;
        #(halfNs / 2);
        sclLine = 1'b1;
        #(halfNs);
        sdaLow = 1'b1;
        #(halfNs);
        sclLine = 1'b0;
    endtask
    task automatic stop();
        sdaLow = 1'b1;
        #(halfNs / 2);
        sclLine = 1'b1;
        #(halfNs);
        sdaLow = 1'b0;
        #(halfNs);
    endtask
    // data moves only with scl low; released bits float up
    task automatic xfer(input logic [7:0] txd, input logic mAck, output logic [7:0] rxd, output logic ack);
        logic [8:0] sh, got;
        sh = {txd, ~mAck};
        for (int i = 8; i >= 0; i--) begin
            sdaLow = ~sh[i];
            #(halfNs / 2);
            sclLine = 1'b1;
            #(halfNs / 2);
            got[i] = sdaLine;
            #(halfNs / 2);
            sclLine = 1'b0;
            #(halfNs / 2);
        end
        rxd = got[8:1];
        ack = ~got[0];
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.vh"
module tb_top;
    logic        clk_sys;
    logic        rst;
    logic [4:0]  regAddr;
    logic [7:0]  regWdata;
    logic        regWr;
    logic        regRd;
    logic [7:0]  regRdata;
    logic        oscIn;
    logic        oscOut;
    logic        eventInput;
    logic        eventDetectOut;
    logic        eventDetectOe;
    logic        sclLine;
    logic        hostSdaLow;
    logic        sdaOut;
    logic        sdaOe;
    logic        irqOrFreqOut;
    logic        irqOrFreqOe;
    logic        intr;
    logic [7:0]  rx;
    logic        ack;
    logic [23:0] calIn [6] = '{24'h00021C, 24'h00021D, 24'h01021C, 24'h03041E, 24'h040C1F, 24'h63021C};
    logic [23:0] calOut [6] = '{24'h00021D, 24'h000301, 24'h010301, 24'h030501, 24'h050101, 24'h630301};
    int          badCount = 0;
    int          testsRun = 0;
    // pull-up on the shared data wire
    wire logic   sdaLine = ~(sdaOe | hostSdaLow);
    rtc_cal_evt #(.DIV(8), .PW(15)) dut (
        .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .oscIn(oscIn), .oscOut(oscOut), .eventInput(eventInput),
        .eventDetectOut(eventDetectOut), .eventDetectOe(eventDetectOe), .sclIn(sclLine), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .irqOrFreqOut(irqOrFreqOut), .irqOrFreqOe(irqOrFreqOe), .intr(intr)
    );
    rtc_i2c_host host (.sclLine(sclLine), .sdaLow(hostSdaLow), .sdaLine(sdaLine));

    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        chk8(regRdata, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // reference edges come at their own phase, stopped between bursts
    task automatic oscPulse(input int n);
        repeat (n) begin
            #24 oscIn <= 1'b1;
            #24 oscIn <= 1'b0;
        end
    endtask
    task automatic testDone();
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (80000) @(posedge clk_sys);
        badCount++;
        testDone();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst        = 1'b1;
        regAddr    = 5'h00;
        regWdata   = 8'h00;
        regWr      = 1'b0;
        regRd      = 1'b0;
        oscIn      = 1'b0;
        eventInput = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        for (int a = 0; a < 20; a++)
            rd(a[4:0], (a == 3 || a == 4) ? 8'h01 : 8'h00);
        wr(`RTC_A_USR0, 8'hA5);
        rd(`RTC_A_USR0, 8'hA5);
        wr(`RTC_A_USR1, 8'h5A);
        rd(`RTC_A_USR1, 8'h5A);
        wr(`RTC_A_STAT, 8'hFF);
        wr(5'h1F, 8'h55);
        rd(5'h1F, 8'h00);
        rd(`RTC_A_STAT, 8'h00);
        wr(`RTC_A_IEN, 8'h02);
        eventInput <= 1'b1;
        idle(8);
        chk1(eventDetectOe, 1'b1);
        chk1(intr, 1'b1);
        rd(`RTC_A_STAT, 8'h02);
        wr(`RTC_A_ICLR, 8'h02);
        eventInput <= 1'b0;
        idle(8);
        chk1(eventDetectOe, 1'b1);
        wr(`RTC_A_IEN, 8'h00);
        idle(2);
        chk1(intr, 1'b0);
        wr(`RTC_A_ICLR, 8'h02);
        idle(2);
        chk1(eventDetectOe, 1'b0);
        rd(`RTC_A_STAT, 8'h00);
        wr(`RTC_A_DOW, 8'h06);
        for (int i = 0; i < 6; i++) begin
            wr(`RTC_A_YEAR, calIn[i][23:16]);
            wr(`RTC_A_MON, calIn[i][15:8]);
            wr(`RTC_A_DATE, calIn[i][7:0]);
            wr(`RTC_A_HOUR, 8'h17);
            wr(`RTC_A_MIN, 8'h3B);
            wr(`RTC_A_SEC, 8'h3B);
            oscPulse(8);
            idle(8);
            rd(`RTC_A_SEC, 8'h00);
            rd(`RTC_A_MIN, 8'h00);
            rd(`RTC_A_HOUR, 8'h00);
            rd(`RTC_A_DOW, i[7:0]);
            rd(`RTC_A_DATE, calOut[i][7:0]);
            rd(`RTC_A_MON, calOut[i][15:8]);
            rd(`RTC_A_YEAR, calOut[i][23:16]);
        end
        wr(`RTC_A_ALSEC, 8'h85);
        wr(`RTC_A_ALMIN, 8'h80);
        wr(`RTC_A_IEN, 8'h01);
        wr(`RTC_A_SEC, 8'h03);
        oscPulse(8);
        idle(8);
        rd(`RTC_A_STAT, 8'h00);
        oscPulse(8);
        idle(8);
        rd(`RTC_A_STAT, 8'h01);
        chk1(intr, 1'b1);
        chk1(irqOrFreqOe, 1'b1);
        oscPulse(8);
        idle(8);
        chk1(irqOrFreqOe, 1'b1);
        wr(`RTC_A_CTRL, 8'h02);
        oscPulse(1);
        idle(8);
        chk1(irqOrFreqOe, 1'b0);
        oscPulse(7);
        idle(8);
        chk1(irqOrFreqOe, 1'b1);
        wr(`RTC_A_ICLR, 8'h01);
        idle(2);
        chk1(irqOrFreqOe, 1'b0);
        host.start();
        host.xfer(8'hDE, 1'b0, rx, ack);
        chk1(ack, 1'b1);
        host.xfer(8'h13, 1'b0, rx, ack);
        host.xfer(8'h3C, 1'b0, rx, ack);
        chk1(ack, 1'b1);
        host.stop();
        idle(2);
        rd(`RTC_A_USR1, 8'h3C);
        host.start();
        host.xfer(8'hDE, 1'b0, rx, ack);
        host.xfer(8'h12, 1'b0, rx, ack);
        host.start();
        host.xfer(8'hDF, 1'b0, rx, ack);
        host.xfer(8'hFF, 1'b0, rx, ack);
        chk8(rx, 8'hA5);
        host.stop();
        host.halfNs = 2500;
        host.start();
        host.xfer(8'hA0, 1'b0, rx, ack);
        chk1(ack, 1'b0);
        host.stop();
        idle(2);
        wr(`RTC_A_FSEL, 8'h01);
        idle(8);
        chk1(irqOrFreqOe, 1'b0);
        wr(`RTC_A_CTRL, 8'h01);
        idle(8);
        chk1(irqOrFreqOe, 1'b1);
        oscIn <= 1'b1;
        idle(8);
        chk1(irqOrFreqOe, 1'b0);
        wr(`RTC_A_FSEL, 8'h00);
        idle(2);
        chk1(irqOrFreqOe, 1'b0);
        testDone();
    end
endmodule

bind rtc_cal_evt rtc_chk u_chk (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .oscIn(oscIn), .oscOut(oscOut), .eventInput(eventInput),
    .eventDetectOut(eventDetectOut), .eventDetectOe(eventDetectOe), .sclIn(sclIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .irqOrFreqOut(irqOrFreqOut)
);
`default_nettype wire
